// ---- rtl/usb_addr_power_ctl.sv ----
/*
  APB register slice of a USB host-or-device controller: the function
  address register and the power control register, with the bus reset,
  resume, suspend, transceiver power-down and line driver controls.
  Assumes an APB master on pclk, a mode input from the controller's mode
  logic and one-cycle event pulses from the link and interrupt logic.
*/
// Contract
// - Reset leaves device mode register values.
// - Address register: 7-bit field, bit 7 zero.
// - Match stored address against incoming tokens in device mode.
// - Power register resets 0x20; host upper nibble 0x2.
// - Power fields depend on active mode.
// - Host bit 3 starts and stops bus reset.
// - Host bit 2 drives resume signalling.
// - Host bit 1 is write-one-to-set suspend.
// - Bit 0 one powers transceiver down.
// - Device bit 6 enables line drivers.
// - Device suspend flag clears on read or resume.
`timescale 1ns/1ns
`include "usb_ctl_defs.svh"

module usb_addr_power_ctl
  import usb_ctl_pkg::*;
#(
  parameter int PADDR_W = 12,
  parameter int ADDR_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_mode,
  input wire logic bus_reset_seen,
  input wire logic suspend_detect,
  input wire logic int_reg_read,
  input wire logic token_valid,
  input wire logic [ADDR_W-1:0] token_address,
  output logic token_match,
  output logic bus_reset_drive,
  output logic resume_drive,
  output logic suspend_drive,
  output logic transceiver_power_down,
  output logic line_drive_enable,
  output logic iso_update
);

  // ************************************************
  // Address decode
  // ************************************************
  localparam logic [PADDR_W-1:0] FADDR_BYTE = PADDR_W'(`FADDR_IDX * `BYTES_PER_REG);
  localparam logic [PADDR_W-1:0] POWER_BYTE = PADDR_W'(`POWER_IDX * `BYTES_PER_REG);

  reg_sel_e sel; // Register picked by the current address
  logic wr_en; // Write completes at this edge
  logic setup; // First cycle of a transfer

  // Decode is purely from paddr, stable for the whole transfer
  always_comb begin
    if (paddr == FADDR_BYTE) begin
      sel = SEL_ADDR;
    end else if (paddr == POWER_BYTE) begin
      sel = SEL_POWER;
    end else begin
      sel = SEL_NONE;
    end
    setup = psel && !penable;
    wr_en = psel && penable && pwrite;
  end

  // Zero wait state slave; unmapped addresses answer with an error
  always_comb begin
    pready = 1'b1;
    pslverr = psel && penable && (sel == SEL_NONE);
  end

  // ************************************************
  // Register state
  // ************************************************
  logic [ADDR_W-1:0] function_address_field; // Stored function address
  logic iso_bit; // Isochronous update, device layout
  logic connect_bit; // Line driver connect, device layout
  logic reset_bit; // Bus reset signalling, host layout
  logic resume_bit; // Resume signalling, both layouts
  logic suspend_active; // Suspend state, both layouts
  logic power_down_bit; // Transceiver power-down, sticky
  // Named once at full width so each flop takes its own bit of the reset value
  localparam logic [7:0] POWER_RESET_VALUE = `POWER_RESET;
  logic [ADDR_W-1:0] next_function_address_field;
  logic next_iso_bit;
  logic next_connect_bit;
  logic next_reset_bit;
  logic next_resume_bit;
  logic next_suspend_active;
  logic next_power_down_bit;
  logic pwr_wr; // Write to the power register
  logic resume_set; // Software sets the resume bit
  logic suspend_set; // Any source that enters suspend
  logic suspend_clr; // Any source that leaves suspend

  // Next state of every control bit; mode picks the field meaning
  always_comb begin
    next_function_address_field = function_address_field;
    next_iso_bit = iso_bit;
    next_connect_bit = connect_bit;
    next_reset_bit = reset_bit;
    next_resume_bit = resume_bit;
    next_power_down_bit = power_down_bit;
    pwr_wr = wr_en && (sel == SEL_POWER);
    resume_set = pwr_wr && pwdata[`PWR_RESUME];
    // Address is writable in either mode; software owns when to load it
    if (wr_en && (sel == SEL_ADDR)) begin
      next_function_address_field = pwdata[`ADDR_MSB:0];
    end
    if (pwr_wr) begin
      next_resume_bit = pwdata[`PWR_RESUME];
      if (host_mode) begin
        // Host layout: bit 3 steers bus reset, upper bits ignored
        next_reset_bit = pwdata[`PWR_RESET];
      end else begin
        // Device layout: bit 3 is status only, bits 7 and 6 writable
        next_iso_bit = pwdata[`PWR_ISO_UPDATE];
        next_connect_bit = pwdata[`PWR_CONNECT];
      end
      // Writing zero leaves power-down alone; only reset undoes it
      if (pwdata[`PWR_POWER_DOWN]) begin
        next_power_down_bit = 1'b1;
      end
    end
    // Suspend is entered by software in host mode, by the link otherwise
    suspend_set = host_mode ? (pwr_wr && pwdata[`PWR_SUSPEND]) : suspend_detect;
    suspend_clr = resume_set || (!host_mode && int_reg_read);
    // An entry in the same cycle as a clear wins, so no event is lost
    if (suspend_set) begin
      next_suspend_active = 1'b1;
    end else if (suspend_clr) begin
      next_suspend_active = 1'b0;
    end else begin
      next_suspend_active = suspend_active;
    end
  end

  // Register update; reset values are those of the device layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_address_field <= `FADDR_RESET;
      iso_bit <= POWER_RESET_VALUE[`PWR_ISO_UPDATE];
      connect_bit <= POWER_RESET_VALUE[`PWR_CONNECT];
      reset_bit <= 1'b0;
      resume_bit <= 1'b0;
      suspend_active <= 1'b0;
      power_down_bit <= 1'b0;
    end else begin
      function_address_field <= next_function_address_field;
      iso_bit <= next_iso_bit;
      connect_bit <= next_connect_bit;
      reset_bit <= next_reset_bit;
      resume_bit <= next_resume_bit;
      suspend_active <= next_suspend_active;
      power_down_bit <= next_power_down_bit;
    end
  end

  // ************************************************
  // Read path
  // ************************************************
  logic [31:0] next_prdata; // Read data captured in the setup cycle
  logic [7:0] power_view; // Power register as software sees it

  // Read view follows the mode; upper word bits always read zero
  always_comb begin
    if (host_mode) begin
      power_view = {`HOST_RSVD_VALUE, reset_bit, resume_bit, suspend_active,
                    power_down_bit};
    end else begin
      power_view = {iso_bit, connect_bit, `DEV_RSVD_VALUE, bus_reset_seen, resume_bit,
                    suspend_active, power_down_bit};
    end
    next_prdata = prdata;
    if (setup && !pwrite) begin
      case (sel)
        SEL_ADDR: begin
          next_prdata = {24'h000000, 1'b0, function_address_field};
        end
        SEL_POWER: begin
          next_prdata = {24'h000000, power_view};
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // Data sampled one cycle early so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ************************************************
  // Link side outputs
  // ************************************************
  // Host-only controls are masked in device mode so a stale bit cannot drive
  always_comb begin
    bus_reset_drive = host_mode && reset_bit;
    resume_drive = resume_bit;
    suspend_drive = host_mode && suspend_active;
    transceiver_power_down = power_down_bit;
    line_drive_enable = host_mode || connect_bit;
    iso_update = !host_mode && iso_bit;
  end

  // Token address compare lives in its own module
  token_address_match #(
    .ADDR_W(ADDR_W)
  ) u_match (
    .pclk(pclk),
    .presetn(presetn),
    .enable(!host_mode),
    .function_address(function_address_field),
    .token_valid(token_valid),
    .token_address(token_address),
    .token_match(token_match)
  );

  // ************************************************
  // Checks
  // ************************************************
  sequence s_read_setup(logic [PADDR_W-1:0] a);
    psel && !penable && !pwrite && (paddr == a);
  endsequence

  property p_addr_rsvd;
    @(posedge pclk) disable iff (!presetn)
      s_read_setup(FADDR_BYTE) |=> (prdata[31:7] == 25'h0000000);
  endproperty
  a_addr_rsvd: assert property (p_addr_rsvd) else $error("address bit 7 not zero");

  property p_addr_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && (paddr == FADDR_BYTE)) |=> (function_address_field == $past(pwdata[`ADDR_MSB:0]));
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("address not stored");

  property p_host_rsvd;
    @(posedge pclk) disable iff (!presetn)
      (s_read_setup(POWER_BYTE) and host_mode) |=> (prdata[7:4] == `HOST_RSVD_VALUE);
  endproperty
  a_host_rsvd: assert property (p_host_rsvd) else $error("host upper nibble wrong");

  property p_bus_reset;
    @(posedge pclk) disable iff (!presetn)
      (pwr_wr && host_mode && pwdata[`PWR_RESET]) ##1 host_mode |-> bus_reset_drive;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset not driven");

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
      pwr_wr |=> (resume_drive == $past(pwdata[`PWR_RESUME]));
  endproperty
  a_resume: assert property (p_resume) else $error("resume drive wrong");

  property p_suspend_w1s;
    @(posedge pclk) disable iff (!presetn)
      (host_mode && suspend_active && pwr_wr && !pwdata[`PWR_SUSPEND] && !pwdata[`PWR_RESUME])
        |=> suspend_active;
  endproperty
  a_suspend_w1s: assert property (p_suspend_w1s) else $error("zero cleared suspend");

  property p_power_down;
    @(posedge pclk) disable iff (!presetn)
      transceiver_power_down |=> transceiver_power_down [*2];
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down undone");

  property p_dev_suspend_clear;
    @(posedge pclk) disable iff (!presetn)
      (!host_mode && int_reg_read && !suspend_detect) |=> !suspend_active;
  endproperty
  a_dev_suspend_clear: assert property (p_dev_suspend_clear) else $error("suspend not cleared");

  // Follows the written connect bit through to the pin enable, not just the wiring
  property p_line_drive;
    @(posedge pclk) disable iff (!presetn)
      (pwr_wr && !host_mode) ##1 !host_mode |-> (line_drive_enable == $past(pwdata[`PWR_CONNECT]));
  endproperty
  a_line_drive: assert property (p_line_drive) else $error("line drive mismatch");

endmodule

// ---- rtl/usb_ctl_defs.svh ----
/*
  Constants of the USB address and power control slice: register indices,
  field positions, reset values and reserved read-back values.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef USB_CTL_DEFS_SVH
`define USB_CTL_DEFS_SVH

// ************************************************
// Register indices, byte address is four times
// ************************************************
`define FADDR_IDX 12'h000
`define POWER_IDX 12'h001
`define BYTES_PER_REG 12'h004

// ************************************************
// Field positions
// ************************************************
`define ADDR_MSB 6
`define PWR_ISO_UPDATE 7
`define PWR_CONNECT 6
`define PWR_RESET 3
`define PWR_RESUME 2
`define PWR_SUSPEND 1
`define PWR_POWER_DOWN 0

// ************************************************
// Reset and reserved values
// ************************************************
`define FADDR_RESET 7'h00
`define POWER_RESET 8'h20
`define HOST_RSVD_VALUE 4'h2
`define DEV_RSVD_VALUE 2'h2

`endif

// ---- rtl/usb_ctl_pkg.sv ----
/*
  Types shared by the USB address and power control slice.
  Assumes nothing of its surroundings.
*/
package usb_ctl_pkg;

  // Which register an APB address selects
  typedef enum logic [1:0] {
    SEL_ADDR  = 2'b00,
    SEL_POWER = 2'b01,
    SEL_NONE  = 2'b10
  } reg_sel_e;

endpackage

// ---- rtl/token_address_match.sv ----
/*
  Compares the address field of each incoming token against the stored
  function address and flags a token meant for this function.
  Assumes token strobes are synchronous to pclk, one cycle each.
*/
`timescale 1ns/1ns
`include "usb_ctl_defs.svh"

module token_address_match #(
  parameter int ADDR_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [ADDR_W-1:0] function_address,
  input wire logic token_valid,
  input wire logic [ADDR_W-1:0] token_address,
  output logic token_match
);

  // ************************************************
  // Compare and register
  // ************************************************
  logic next_token_match; // Match result for this token

  // Only in device mode is an address compared at all
  always_comb begin
    next_token_match = enable && token_valid && (token_address == function_address);
  end

  // Registered so the match pulse is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      token_match <= 1'b0;
    end else begin
      token_match <= next_token_match;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  sequence s_own_token;
    enable && token_valid && (token_address == function_address);
  endsequence

  property p_token_match;
    @(posedge pclk) disable iff (!presetn)
      s_own_token |=> token_match;
  endproperty
  a_token_match: assert property (p_token_match) else $error("own token not flagged");

  property p_token_foreign;
    @(posedge pclk) disable iff (!presetn)
      !(enable && token_valid && (token_address == function_address)) |=> !token_match;
  endproperty
  a_token_foreign: assert property (p_token_foreign) else $error("foreign token flagged");

endmodule

// ---- verification/usb_peer_model.sv ----
/*
  Far-side USB peer: sends token addresses and link events to the slice.
  Assumes pclk from the bench; all changes land just after rising edges.
*/
`timescale 1ns/1ns

module usb_peer_model (
  input wire logic pclk,
  output logic token_valid,
  output logic [6:0] token_address,
  output logic bus_reset_seen,
  output logic suspend_detect
);
  // ********************
  // Idle line values
  // ********************
  initial begin
    token_valid = 1'b0;
    token_address = 7'h55;
    bus_reset_seen = 1'b0;
    suspend_detect = 1'b0;
  end

  // One token; the address is then inverted so a stale copy never matches
  task automatic send_token(input logic [6:0] a);
    @(posedge pclk);
    token_valid <= 1'b1;
    token_address <= a;
    @(posedge pclk);
    token_valid <= 1'b0;
    token_address <= ~a;
  endtask

  // One-cycle idle-bus detection pulse
  task automatic idle_seen();
    @(posedge pclk);
    suspend_detect <= 1'b1;
    @(posedge pclk);
    suspend_detect <= 1'b0;
  endtask

  // Bus reset seen on the wire, as a level
  task automatic line_reset(input logic v);
    @(posedge pclk);
    bus_reset_seen <= v;
  endtask
endmodule

// ---- verification/usb_addr_power_ctl_tb.sv ----
/*
  Self-checking bench for the USB address and power control slice.
  Assumes the design headers on the include path and the peer model.
*/
`timescale 1ns/1ns
`include "usb_ctl_defs.svh"

module usb_addr_power_ctl_tb import usb_ctl_pkg::*;;
  // ********************
  // Signals
  // ********************
  localparam logic [11:0] A_ADDR = `FADDR_IDX * `BYTES_PER_REG;
  localparam logic [11:0] A_PWR = `POWER_IDX * `BYTES_PER_REG;
  localparam logic [11:0] A_BAD = 12'h008; // Unmapped word
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic int_reg_read, token_valid, token_match, bus_reset_seen, suspend_detect;
  logic [6:0] token_address;
  logic bus_reset_drive, resume_drive, suspend_drive;
  logic transceiver_power_down, line_drive_enable, iso_update, err;
  int fail_count = 0;
  int n_compared = 0;

  usb_addr_power_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_mode(host_mode),
    .bus_reset_seen(bus_reset_seen), .suspend_detect(suspend_detect),
    .int_reg_read(int_reg_read), .token_valid(token_valid),
    .token_address(token_address), .token_match(token_match),
    .bus_reset_drive(bus_reset_drive), .resume_drive(resume_drive),
    .suspend_drive(suspend_drive), .transceiver_power_down(transceiver_power_down),
    .line_drive_enable(line_drive_enable), .iso_update(iso_update));

  usb_peer_model peer (.pclk(pclk), .token_valid(token_valid),
    .token_address(token_address), .bus_reset_seen(bus_reset_seen),
    .suspend_detect(suspend_detect));

  // ********************
  // Shared tasks
  // ********************
  task automatic wrap_up();
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    check({31'h0, err}, 32'h0000_0000);
  endtask

  // Let a write's effect reach the control outputs
  task automatic step();
    @(posedge pclk);
    #1;
  endtask

  task automatic set_mode(input logic h);
    @(posedge pclk);
    host_mode <= h;
    step();
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    rdchk(A_ADDR, 32'h0000_0000);
    rdchk(A_PWR, 32'h0000_0020);
    check({bus_reset_drive, resume_drive, suspend_drive, transceiver_power_down}, 0);
    check(line_drive_enable, 1'b0);
  endtask

  task automatic t_address();
    apb(1'b1, A_ADDR, 32'h0000_00FF);
    rdchk(A_ADDR, 32'h0000_007F);
    apb(1'b1, A_ADDR, 32'h0000_002A);
    peer.send_token(7'h2A);
    #1 check(token_match, 1'b1);
    peer.send_token(7'h2B);
    #1 check(token_match, 1'b0);
  endtask

  task automatic t_host();
    set_mode(1'b1);
    check(line_drive_enable, 1'b1);
    peer.send_token(7'h2A);
    #1 check(token_match, 1'b0);
    rdchk(A_PWR, 32'h0000_0020);
    apb(1'b1, A_PWR, 32'h0000_0028);
    step();
    check(bus_reset_drive, 1'b1);
    apb(1'b1, A_PWR, 32'h0000_00F0);
    step();
    check(bus_reset_drive, 1'b0);
    rdchk(A_PWR, 32'h0000_0020);
    apb(1'b1, A_PWR, 32'h0000_0022);
    apb(1'b1, A_PWR, 32'h0000_0020);
    step();
    check(suspend_drive, 1'b1);
    rdchk(A_PWR, 32'h0000_0022);
    apb(1'b1, A_PWR, 32'h0000_0024);
    step();
    check({resume_drive, suspend_drive}, 2'b10);
    apb(1'b1, A_PWR, 32'h0000_0020);
    step();
    check(resume_drive, 1'b0);
  endtask

  task automatic t_device();
    set_mode(1'b0);
    apb(1'b1, A_PWR, 32'h0000_00E8);
    step();
    check({line_drive_enable, iso_update}, 2'b11);
    peer.line_reset(1'b1);
    rdchk(A_PWR, 32'h0000_00E8);
    peer.line_reset(1'b0);
    peer.idle_seen();
    rdchk(A_PWR, 32'h0000_00E2);
    check(suspend_drive, 1'b0);
    @(posedge pclk);
    int_reg_read <= 1'b1;
    @(posedge pclk);
    int_reg_read <= 1'b0;
    rdchk(A_PWR, 32'h0000_00E0);
    peer.idle_seen();
    apb(1'b1, A_PWR, 32'h0000_0024);
    rdchk(A_PWR, 32'h0000_0024);
    check(line_drive_enable, 1'b0);
  endtask

  task automatic t_power_down();
    apb(1'b1, A_PWR, 32'h0000_0021);
    apb(1'b1, A_PWR, 32'h0000_0020);
    step();
    check(transceiver_power_down, 1'b1);
    apb(1'b0, A_BAD, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    apb(1'b1, A_BAD, 32'h0000_0011);
    check({31'h0, err}, 32'h0000_0001);
    rdchk(A_ADDR, 32'h0000_002A);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_PWR, 32'h0000_0020);
    check(transceiver_power_down, 1'b0);
  endtask

  // ********************
  // Clock, reset, run
  // ********************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, host_mode, int_reg_read} = 6'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_address();
    t_host();
    t_device();
    t_power_down();
    wrap_up();
  end
endmodule
